// [hdl/ccr_pkg.sv]
// Purpose: Shared constants and types for the charger control register bank
// Assumes: 250 MHz core clock, 8-bit registers behind a two-wire serial target
// Notes: Field structs double as the carriers on the top-level ports
package ccr_pkg;

    // Register offsets and values after reset or a reset command
    localparam logic [7:0] ADDR_CTRL_B = 8'h06;
    localparam logic [7:0] ADDR_CTRL_C = 8'h07;
    localparam logic [7:0] ADDR_CTRL_D = 8'h08;
    localparam logic [7:0] RST_CTRL_B = 8'h7d;
    localparam logic [7:0] RST_CTRL_C = 8'h02;
    localparam logic [7:0] RST_CTRL_D = 8'h0d;

    // Bits that a watchdog expiry reloads; the rest keep their contents
    localparam logic [7:0] WDR_MASK_B = 8'hfc;
    localparam logic [7:0] WDR_MASK_C = 8'h70;
    localparam logic [7:0] WDR_MASK_D = 8'hff;

    // Field encodings consumed by the analog side
    localparam logic [1:0] THERM_60C = 2'h0;
    localparam logic [1:0] THERM_120C = 2'h3;
    localparam logic [1:0] TOPOFF_OFF = 2'h0;
    localparam logic [1:0] HOT_PROT_OFF = 2'h3;
    localparam logic [1:0] WARM_SUSPEND = 2'h0;
    localparam logic [1:0] COOL_SUSPEND = 2'h0;

    // Watchdog period codes and their lengths in seconds
    localparam logic [1:0] WD_OFF = 2'h0;
    localparam int WD_SEC_40 = 40;
    localparam int WD_SEC_80 = 80;
    localparam int WD_SEC_160 = 160;

    // One-second tick derived from the clock rate
    localparam int CLK_MHZ = 250;
    localparam int TICK_S = 1;
    localparam int TICK_CYCLES = TICK_S * 1_000_000 * CLK_MHZ;

    typedef struct packed {
        logic reverse_buck_enable;
        logic auto_port_detect_enable;
        logic [1:0] thermal_reg_threshold;
        logic charge_enable;
        logic precharge_exit_threshold;
        logic [1:0] recharge_offset;
    } ccr_ctrl_b_t;

    typedef struct packed {
        logic pulse_mode_disable;
        logic watchdog_kick;
        logic [1:0] topoff_duration;
        logic [3:0] min_system_voltage;
    } ccr_ctrl_c_t;

    typedef struct packed {
        logic [1:0] otg_hot_threshold;
        logic otg_cold_threshold;
        logic [1:0] warm_band_voltage_sel;
        logic warm_band_current_sel;
        logic [1:0] cool_band_current_sel;
    } ccr_ctrl_d_t;

    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_AACK, S_REG, S_RACK, S_WDATA, S_WACK, S_RDATA, S_MACK
    } ccr_state_t;

endpackage

// [hdl/ccr_top.sv]
// Purpose: Charger control registers B, C, D with serial target and watchdog
// Assumes: SCL, SDA and VBUS_ATTACH are asynchronous pins; REG_RESET and
//          WD_PERIOD come from logic on CLK
// Notes: Register pointer auto-increments; unmapped offsets read 00, ignore writes
`timescale 1ns/1ps
`default_nettype none

module ccr_top #(
    parameter logic [6:0] DEV_ADDR = 7'h2a, // Arbitrary target address
    parameter int unsigned SEC_CYCLES = ccr_pkg::TICK_CYCLES
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    input wire logic VBUS_ATTACH,
    input wire logic REG_RESET,
    input wire logic [1:0] WD_PERIOD,
    output ccr_pkg::ccr_ctrl_b_t CTRL_B,
    output ccr_pkg::ccr_ctrl_c_t CTRL_C,
    output ccr_pkg::ccr_ctrl_d_t CTRL_D,
    output logic REVERSE_BUCK_ACTIVE,
    output logic CHARGE_ACTIVE,
    output logic DETECT_START,
    output logic WD_EXPIRED
);
    import ccr_pkg::*;

    localparam int SEC_W = $clog2(SEC_CYCLES + 1);

    logic rst_m, rst_n;
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic vbus_m, vbus_s, vbus_d;
    logic i2c_start, i2c_stop, scl_rise, scl_fall, vbus_rise;
    ccr_state_t st;
    logic [3:0] cnt;
    logic [7:0] shreg, tx, ptr, wr_addr, wr_data;
    logic rw, wr_pulse;
    logic [SEC_W-1:0] sec_cnt;
    logic [7:0] wd_sec;
    logic [1:0] wd_period_d;
    logic wd_fire, wd_restart;
    logic [39:0] wd_age;

    // Byte seen by a read at the given offset
    function automatic logic [7:0] reg_read(input logic [7:0] a, input ccr_ctrl_b_t b,
                                            input ccr_ctrl_c_t c, input ccr_ctrl_d_t d);
        case (a)
            ADDR_CTRL_B: reg_read = b;
            ADDR_CTRL_C: reg_read = c;
            ADDR_CTRL_D: reg_read = d;
            default: reg_read = 8'h00;
        endcase
    endfunction

    // Put masked bits back to their reset value
    function automatic logic [7:0] reload(input logic [7:0] cur, input logic [7:0] rst,
                                          input logic [7:0] mask);
        reload = (cur & ~mask) | (rst & mask);
    endfunction

    // Watchdog length in seconds for a period code
    function automatic logic [7:0] wd_limit(input logic [1:0] code);
        case (code)
            2'h1: wd_limit = 8'(WD_SEC_40);
            2'h2: wd_limit = 8'(WD_SEC_80);
            2'h3: wd_limit = 8'(WD_SEC_160);
            default: wd_limit = 8'h00;
        endcase
    endfunction

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // Pin synchronisers; only the second stage and later are looked at
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
            {vbus_m, vbus_s, vbus_d} <= 3'h0;
        end else begin
            {scl_m, scl_s, scl_d} <= {SCL, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {SDA_IN, sda_m, sda_s};
            {vbus_m, vbus_s, vbus_d} <= {VBUS_ATTACH, vbus_m, vbus_s};
        end
    end

    // Bus conditions and edges from synchronised copies
    assign i2c_start = scl_s && scl_d && sda_d && !sda_s;
    assign i2c_stop = scl_s && scl_d && !sda_d && sda_s;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign vbus_rise = vbus_s && !vbus_d;

    // Serial target: data sampled on SCL rise, SDA changed only after SCL fall
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            st <= S_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            wr_pulse <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            SDA_OE_N <= 1'b1;
        end else begin
            wr_pulse <= 1'b0;
            if (i2c_start) begin
                st <= S_ADDR;
                cnt <= 4'h0;
                SDA_OE_N <= 1'b1;
            end else if (i2c_stop) begin
                st <= S_IDLE;
                SDA_OE_N <= 1'b1;
            end else if (scl_rise) begin
                if (st == S_ADDR || st == S_REG || st == S_WDATA) begin
                    shreg <= {shreg[6:0], sda_s};
                    cnt <= cnt + 4'h1;
                end else if (st == S_RDATA) begin
                    cnt <= cnt + 4'h1;
                end else if (st == S_MACK && sda_s) begin
                    st <= S_IDLE; // Master NACK ends the read
                end
            end else if (scl_fall) begin
                unique case (st)
                    S_IDLE: begin
                    end
                    S_ADDR: begin
                        if (cnt == 4'h8) begin
                            if (shreg[7:1] == DEV_ADDR) begin
                                st <= S_AACK;
                                rw <= shreg[0];
                                SDA_OE_N <= 1'b0;
                            end else begin
                                st <= S_IDLE;
                            end
                        end
                    end
                    S_AACK, S_MACK: begin
                        cnt <= 4'h0;
                        if (st == S_MACK || rw) begin
                            st <= S_RDATA;
                            tx <= reg_read(ptr, CTRL_B, CTRL_C, CTRL_D);
                            SDA_OE_N <= 1'(reg_read(ptr, CTRL_B, CTRL_C, CTRL_D) >> 7);
                        end else begin
                            st <= S_REG;
                            SDA_OE_N <= 1'b1;
                        end
                    end
                    S_REG: begin
                        if (cnt == 4'h8) begin
                            ptr <= shreg;
                            st <= S_RACK;
                            SDA_OE_N <= 1'b0;
                        end
                    end
                    S_RACK, S_WACK: begin
                        st <= S_WDATA;
                        cnt <= 4'h0;
                        SDA_OE_N <= 1'b1;
                    end
                    S_WDATA: begin
                        if (cnt == 4'h8) begin
                            wr_pulse <= 1'b1;
                            wr_addr <= ptr;
                            wr_data <= shreg;
                            ptr <= ptr + 8'h01;
                            st <= S_WACK;
                            SDA_OE_N <= 1'b0;
                        end
                    end
                    S_RDATA: begin
                        if (cnt == 4'h8) begin
                            st <= S_MACK;
                            ptr <= ptr + 8'h01;
                            SDA_OE_N <= 1'b1;
                        end else begin
                            SDA_OE_N <= tx[6];
                            tx <= {tx[6:0], 1'b0};
                        end
                    end
                endcase
            end
        end
    end

    // Open-drain: the driven level is always low, the enable carries data
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            SDA_OUT <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
        end
    end

    // Register file: command reset beats a host write and expiry, a host write beats expiry
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            CTRL_B <= RST_CTRL_B;
            CTRL_C <= RST_CTRL_C;
            CTRL_D <= RST_CTRL_D;
        end else if (REG_RESET) begin
            CTRL_B <= RST_CTRL_B;
            CTRL_C <= RST_CTRL_C;
            CTRL_D <= RST_CTRL_D;
        end else begin
            if (wd_fire) begin
                CTRL_B <= reload(CTRL_B, RST_CTRL_B, WDR_MASK_B);
                CTRL_C <= reload(CTRL_C, RST_CTRL_C, WDR_MASK_C);
                CTRL_D <= reload(CTRL_D, RST_CTRL_D, WDR_MASK_D);
            end else if (CTRL_C.watchdog_kick) begin
                CTRL_C.watchdog_kick <= 1'b0;
            end
            if (wr_pulse) begin
                case (wr_addr)
                    ADDR_CTRL_B: CTRL_B <= wr_data;
                    ADDR_CTRL_C: CTRL_C <= wr_data;
                    ADDR_CTRL_D: CTRL_D <= wr_data;
                    default: begin
                    end
                endcase
            end
        end
    end

    // Watchdog restarts on kick, period change or command reset
    assign wd_restart = CTRL_C.watchdog_kick || REG_RESET || (WD_PERIOD != wd_period_d);
    assign wd_fire = (WD_PERIOD != WD_OFF) && !wd_restart && (sec_cnt == SEC_W'(SEC_CYCLES - 1))
                     && (wd_sec == wd_limit(WD_PERIOD) - 8'h01);

    // Second prescaler and second counter; the 8-bit count covers 160 s
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt <= '0;
            wd_sec <= 8'h00;
            wd_period_d <= WD_OFF;
            WD_EXPIRED <= 1'b0;
        end else begin
            wd_period_d <= WD_PERIOD;
            WD_EXPIRED <= wd_fire;
            if (wd_restart || wd_fire || WD_PERIOD == WD_OFF) begin
                sec_cnt <= '0;
                wd_sec <= 8'h00;
            end else if (sec_cnt == SEC_W'(SEC_CYCLES - 1)) begin
                sec_cnt <= '0;
                wd_sec <= wd_sec + 8'h01;
            end else begin
                sec_cnt <= sec_cnt + SEC_W'(1);
            end
        end
    end

    // Cycles since restart, kept apart from the prescaler that it checks
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            wd_age <= 40'h0;
        end else begin
            wd_age <= (wd_restart || wd_fire || WD_PERIOD == WD_OFF) ? 40'h0 : wd_age + 40'h1;
        end
    end

    // Mode outputs; OTG only runs while charging is not requested
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            REVERSE_BUCK_ACTIVE <= 1'b0;
            CHARGE_ACTIVE <= 1'b0;
            DETECT_START <= 1'b0;
        end else begin
            REVERSE_BUCK_ACTIVE <= CTRL_B.reverse_buck_enable && !CTRL_B.charge_enable;
            CHARGE_ACTIVE <= CTRL_B.charge_enable;
            DETECT_START <= vbus_rise && CTRL_B.auto_port_detect_enable;
        end
    end

    // Checks on the register, mode and watchdog behaviour
    sequence s_kick_write;
        wr_pulse && wr_addr == ADDR_CTRL_C && wr_data[6] && !REG_RESET;
    endsequence

    sequence s_kick_done;
        CTRL_C.watchdog_kick ##1 (!CTRL_C.watchdog_kick && wd_sec == 8'h00);
    endsequence

    sequence s_clean_expiry;
        wd_fire && !REG_RESET && !wr_pulse;
    endsequence

    a_kick_self_clear: assert property (s_kick_write |=> s_kick_done)
        else $error("kick bit did not restart watchdog and clear");
    a_otg_priority: assert property (CTRL_B.reverse_buck_enable && CTRL_B.charge_enable
        |=> !REVERSE_BUCK_ACTIVE && CHARGE_ACTIVE)
        else $error("OTG active while charge enabled");
    a_otg_alone: assert property (CTRL_B.reverse_buck_enable && !CTRL_B.charge_enable
        |=> REVERSE_BUCK_ACTIVE)
        else $error("OTG request not honoured");
    a_detect_start: assert property (vbus_rise |=>
        DETECT_START == $past(CTRL_B.auto_port_detect_enable))
        else $error("detection start does not follow enable bit");
    a_detect_quiet: assert property (!vbus_rise |=> !DETECT_START)
        else $error("detection started without attach");
    a_cmd_reset_b: assert property (REG_RESET |=> CTRL_B == RST_CTRL_B
        && CTRL_B.thermal_reg_threshold == THERM_120C)
        else $error("register B not at reset value after command");
    a_cmd_reset_c: assert property (REG_RESET |=> CTRL_C == RST_CTRL_C
        && CTRL_C.topoff_duration == TOPOFF_OFF)
        else $error("register C not at reset value after command");
    a_cmd_reset_d: assert property (REG_RESET |=> CTRL_D == RST_CTRL_D)
        else $error("register D not at reset value after command");
    a_wd_keep: assert property (s_clean_expiry |=>
        CTRL_B.recharge_offset == $past(CTRL_B.recharge_offset)
        && CTRL_C.pulse_mode_disable == $past(CTRL_C.pulse_mode_disable)
        && CTRL_C.min_system_voltage == $past(CTRL_C.min_system_voltage))
        else $error("watchdog expiry changed a kept field");
    a_wd_reload: assert property (s_clean_expiry |=>
        (CTRL_B & WDR_MASK_B) == (RST_CTRL_B & WDR_MASK_B)
        && (CTRL_C & WDR_MASK_C) == (RST_CTRL_C & WDR_MASK_C)
        && CTRL_D == RST_CTRL_D && WD_EXPIRED)
        else $error("watchdog expiry did not reload fields");
    a_wd_period: assert property (wd_fire == (WD_PERIOD != WD_OFF && !wd_restart
        && wd_age == 40'(wd_limit(WD_PERIOD)) * 40'(SEC_CYCLES) - 40'h1))
        else $error("watchdog fired at wrong count");

endmodule

`default_nettype wire

// [test/ccr_host_model.sv]
// Purpose: Serial host that drives the two-wire bus of the register bank
// Assumes: Data line has a pull-up; only the host drives the clock line
// Notes: Each clock phase lasts 2*Q cycles, well above the 4-cycle minimum
`timescale 1ns/1ps
`default_nettype none

module ccr_host_model #(
    parameter int Q = 6
) (
    input wire logic CLK,
    input wire logic SDA,
    output logic SCL,
    output logic SDA_DRV
);
    // Idle bus: clock high, data released
    initial begin
        SCL = 1'b1;
        SDA_DRV = 1'b1;
    end

    // Lines only move just after a clock edge, never on it
    task automatic step();
        repeat (Q) @(posedge CLK);
        #1;
    endtask

    // Start or repeated start: data falls while the clock is high
    task automatic start();
        step();
        SDA_DRV = 1'b1;
        step();
        SCL = 1'b1;
        step();
        SDA_DRV = 1'b0;
        step();
        SCL = 1'b0;
    endtask

    // Stop: data rises while the clock is high, then the bus idles
    task automatic stop();
        step();
        SDA_DRV = 1'b0;
        step();
        SCL = 1'b1;
        step();
        SDA_DRV = 1'b1;
        step();
    endtask

    // Nine slots MSB first; a 1 releases the line so the bank may answer
    task automatic io(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            step();
            SDA_DRV = tx[i];
            step();
            SCL = 1'b1;
            step();
            rx[i] = SDA;
            step();
            SCL = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// [test/tb_ccr_top.sv]
// Purpose: Self-checking bench for the charger control register bank
// Assumes: Host model on the serial pins; watchdog second cut to SEC cycles
// Notes: Expected values come from field layouts and reset values
`timescale 1ns/1ps
`default_nettype none

module tb_ccr_top;
    import ccr_pkg::*;
    localparam int SEC = 50;
    localparam int LIMIT = 60000;
    localparam logic [6:0] DEV = 7'h2a;
    logic clk, rst_n, scl, sda_drv, vbus, reg_rst;
    logic sda_out, sda_oe_n, rb_act, chg_act, det, wd_exp;
    logic [1:0] wd_per;
    logic [23:0] rd;
    logic [8:0] rx;
    logic [7:0] pat [5] = '{8'h00, 8'h55, 8'haa, 8'hff, 8'h80};
    ccr_ctrl_b_t cb;
    ccr_ctrl_c_t cc;
    ccr_ctrl_d_t cd;
    wire logic sda;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_det = 0;
    int n_kick = 0;
    int kick_cyc = 0;
    int n, d0, m;

    // Open-drain data line: high unless the host or the bank pulls it low
    assign sda = sda_drv & (sda_oe_n | sda_out);

    ccr_top #(.DEV_ADDR(DEV), .SEC_CYCLES(SEC)) DUT (
        .CLK(clk), .RESET_N(rst_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE_N(sda_oe_n), .VBUS_ATTACH(vbus), .REG_RESET(reg_rst), .WD_PERIOD(wd_per),
        .CTRL_B(cb), .CTRL_C(cc), .CTRL_D(cd), .REVERSE_BUCK_ACTIVE(rb_act),
        .CHARGE_ACTIVE(chg_act), .DETECT_START(det), .WD_EXPIRED(wd_exp)
    );

    ccr_host_model host (.CLK(clk), .SDA(sda), .SCL(scl), .SDA_DRV(sda_drv));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Cycle count, pulse counters and the hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cc.watchdog_kick === 1'b1) begin
            n_kick <= n_kick + 1;
            kick_cyc <= cyc;
        end
        if (det === 1'b1) begin
            n_det <= n_det + 1;
        end
        if (cyc == LIMIT) begin
            n_fail = n_fail + 1;
            stop_test();
        end
    end

    task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    // Three-byte write from ptr; every byte must be acknowledged
    task automatic wr_regs(input logic [7:0] ptr, input logic [23:0] d);
        logic [39:0] w;
        logic ok;
        w = {DEV, 1'b0, ptr, d};
        ok = 1'b1;
        host.start();
        for (int i = 4; i >= 0; i--) begin
            host.io({w[i*8 +: 8], 1'b1}, rx);
            ok &= ~rx[0];
        end
        host.stop();
        check_bit(ok, 1'b1);
    endtask

    // Three-byte read from ptr via a repeated start; last byte is refused
    task automatic rd_regs(input logic [7:0] ptr, output logic [23:0] d);
        host.start();
        host.io({DEV, 1'b0, 1'b1}, rx);
        host.io({ptr, 1'b1}, rx);
        host.start();
        host.io({DEV, 1'b1, 1'b1}, rx);
        for (int i = 2; i >= 0; i--) begin
            host.io({8'hff, i == 0}, rx);
            d[i*8 +: 8] = rx[8:1];
        end
        host.stop();
    endtask

    // Counts cycles until the expiry pulse, giving up at lim
    task automatic wait_wd(input int lim, output int got);
        got = 0;
        do begin
            @(posedge clk);
            #1;
            got++;
        end while (wd_exp !== 1'b1 && got < lim);
    endtask

    task automatic end_test(input string name);
        $display("Test done: %s", name);
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        vbus = 1'b0;
        reg_rst = 1'b0;
        wd_per = 2'h0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check_word({cb, cc, cd}, 24'h7d020d);
        rd_regs(8'h06, rd);
        check_word(rd, 24'h7d020d);
        check_bit(chg_act, 1'b1);
        end_test("reset values");
        // Patterns hit every code of every two-bit field; the kick reads back 0
        foreach (pat[i]) begin
            wr_regs(8'h06, {3{pat[i]}});
            rd_regs(8'h06, rd);
            check_word(rd, {pat[i], pat[i] & 8'hbf, pat[i]});
            check_word({cb, cc, cd}, {pat[i], pat[i] & 8'hbf, pat[i]});
            check_bit(chg_act, pat[i][3]);
            check_bit(rb_act, pat[i][7] & ~pat[i][3]);
            d0 = n_det;
            vbus = 1'b1;
            repeat (8) @(posedge clk);
            #1 vbus = 1'b0;
            repeat (8) @(posedge clk);
            #1;
            check_bit((n_det - d0) == int'(pat[i][6]), 1'b1);
        end
        end_test("field codes");
        // Unmapped offsets ignore writes and read 00; the pointer runs past 08h
        wr_regs(8'h09, 24'hffffff);
        rd_regs(8'h08, rd);
        check_word(rd, 24'h800000);
        host.start();
        host.io({DEV ^ 7'h01, 1'b0, 1'b1}, rx);
        host.stop();
        check_bit(rx[0], 1'b1);
        end_test("unmapped and foreign address");
        reg_rst = 1'b1;
        @(posedge clk);
        #1 reg_rst = 1'b0;
        check_word({cb, cc, cd}, 24'h7d020d);
        end_test("reset command");
        // Each period code; expiry keeps only the offset, pulse and voltage fields
        wr_regs(8'h06, 24'hffbfff);
        for (int k = 1; k <= 3; k++) begin
            m = 1 << (k - 1);
            wd_per = 2'(k);
            wait_wd(SEC * 170, n);
            check_bit((n >= SEC * 40 * m - 2) && (n <= SEC * 40 * m + 6), 1'b1);
            check_word({cb, cc, cd}, 24'h7f8f0d);
        end
        end_test("watchdog periods");
        // A kick part-way through restarts the full period and self-clears
        wd_per = 2'h1;
        repeat (SEC * 10) @(posedge clk);
        #1 d0 = n_kick;
        wr_regs(8'h07, 24'hc00000);
        wait_wd(SEC * 45, n);
        check_bit(((cyc - kick_cyc) >= SEC * 40 - 2) && ((cyc - kick_cyc) <= SEC * 40 + 6), 1'b1);
        check_bit((n_kick - d0) == 1, 1'b1);
        rd_regs(8'h07, rd);
        check_word(rd, 24'h800d00);
        wd_per = 2'h0;
        wait_wd(SEC * 42, n);
        check_bit(n == SEC * 42, 1'b1);
        end_test("watchdog kick");
        stop_test();
    end
endmodule

`default_nettype wire
